// [src/acrb_pkg.sv]
package acrb_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [8:0] ADDR_CHAN_LO   = 9'h004;
  localparam logic [8:0] ADDR_CHAN_HI   = 9'h005;
  localparam logic [8:0] ADDR_PWR_MODE  = 9'h008;
  localparam logic [8:0] ADDR_ENH_CTRL  = 9'h00C;
  localparam logic [8:0] ADDR_PATT1_LO  = 9'h019;
  localparam logic [8:0] ADDR_PATT1_HI  = 9'h01A;
  localparam logic [8:0] ADDR_PATT2_LO  = 9'h01B;
  localparam logic [8:0] ADDR_PATT2_HI  = 9'h01C;
  localparam logic [8:0] ADDR_SER_CTRL  = 9'h021;
  localparam logic [8:0] ADDR_CHAN_STAT = 9'h022;
  localparam logic [8:0] ADDR_TRANSFER  = 9'h0FF;
  localparam logic [8:0] ADDR_OVERRIDE  = 9'h100;
  localparam logic [8:0] ADDR_IO_CTRL2  = 9'h101;
  localparam logic [8:0] ADDR_IO_CTRL3  = 9'h102;
  localparam logic [8:0] ADDR_SYNC      = 9'h109;

  // ----------------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_SER_CTRL   = 8'h42;
  localparam logic [3:0] CHAN_ALL       = 4'hF;
  localparam int         NUM_DATA_CH    = 8;
  localparam int         NUM_CLK_CH     = 2;
  localparam int         PD_PIN_BIT     = 5;
  localparam int         CHOP_BIT       = 2;
  localparam int         STAT_PD_BIT    = 0;
  localparam int         STAT_ORST_BIT  = 1;
  localparam int         XFER_BIT       = 0;
  localparam int         CLKCH_SEL_LSB  = 4;
  localparam logic [7:0] MASK_PWR_MODE  = 8'h23;
  localparam logic [7:0] MASK_ENH_CTRL  = 8'h04;
  localparam logic [7:0] MASK_CHAN_STAT = 8'h03;
  localparam logic [7:0] MASK_OVERRIDE  = 8'h77;
  localparam logic [7:0] MASK_IO_CTRL2  = 8'h01;
  localparam logic [7:0] MASK_IO_CTRL3  = 8'h08;
  localparam logic [7:0] MASK_SYNC      = 8'h03;
  localparam logic [7:0] MASK_CHAN_HI   = 8'h3F;

  // ----------------------------------------------------------------------
  // Internal power-down mode encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_NORMAL    = 2'h0,
    PM_POWERDOWN = 2'h1,
    PM_STANDBY   = 2'h2,
    PM_DIGRESET  = 2'h3
  } acrb_pmode_t;

endpackage

// [src/acrb_chan_ctrl.sv]
`timescale 1ns/1ps
// Per-channel status bits; only channels whose select bit is set are written
module acrb_chan_ctrl (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Write strobe and data
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_bits,
  input  wire logic       sel,
  // Stored state
  output logic      [1:0] bits_q
);

  // -----------------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------------
  // Local write only lands on a selected channel
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bits_q <= 2'h0;
    end else if (wr_en && sel) begin
      bits_q <= wr_bits;
    end
  end

endmodule

// [src/acrb_regs.sv]
`timescale 1ns/1ps
module acrb_regs (
  // Clock and power-on reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register port from the serial interface
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // External power-down pin
  input  wire logic        external_power_down_pin,
  // Data path controls per data channel
  output logic      [7:0]  dp_clk_en,
  output logic      [7:0]  dp_reset,
  output logic      [7:0]  dp_out_en,
  // Output clock channel controls
  output logic      [1:0]  oclk_out_en,
  output logic      [1:0]  oclk_reset,
  // Feature controls
  output logic             chop_en,
  output logic      [15:0] user_pattern_one,
  output logic      [15:0] user_pattern_two,
  output logic      [7:0]  serial_ctrl,
  output logic      [7:0]  override_active,
  output logic             sdio_pulldown_dis,
  output logic             common_mode_generator_pd,
  output logic      [1:0]  sync_ctrl
);

  // -----------------------------------------------------------------------
  // Storage
  // -----------------------------------------------------------------------
  logic [7:0]  chan_lo_q;
  logic [7:0]  chan_hi_q;
  logic [7:0]  pwr_mode_q;
  logic [7:0]  enh_ctrl_q;
  logic [7:0]  patt1_lo_q;
  logic [7:0]  patt1_hi_q;
  logic [7:0]  patt2_lo_q;
  logic [7:0]  patt2_hi_q;
  logic [7:0]  ser_ctrl_q;
  logic [7:0]  override_q;
  logic [7:0]  override_act_q;
  logic [7:0]  io_ctrl2_q;
  logic [7:0]  io_ctrl3_q;
  logic [7:0]  sync_q;
  logic [9:0]  sel_vec;
  logic [1:0]  stat_q [10];
  logic [7:0]  stat_rd;
  logic        stat_wr;
  logic        stat_rd_any;
  acrb_pkg::acrb_pmode_t eff_mode;

  // Write decode shared by every register
  function automatic logic hit_wr(input logic       wr,
                                  input logic [8:0] a,
                                  input logic [8:0] target);
    hit_wr = wr && (a == target);
  endfunction

  // -----------------------------------------------------------------------
  // Channel selection
  // -----------------------------------------------------------------------
  // Data channels 0-3 from the low index, 4-7 and clock channels from the high
  // Bits 7:6 of the high index are dropped, so they select nothing
  always_comb begin
    sel_vec = {chan_hi_q[acrb_pkg::CLKCH_SEL_LSB +: 2], chan_hi_q[3:0], chan_lo_q[3:0]};
  end

  // -----------------------------------------------------------------------
  // Directly updated registers
  // -----------------------------------------------------------------------
  // The whole bank sits on power-on reset only; no power mode touches it
  // Reserved bits are masked on write so they always read back zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_lo_q  <= {4'h0, acrb_pkg::CHAN_ALL};
      chan_hi_q  <= acrb_pkg::MASK_CHAN_HI;
      pwr_mode_q <= acrb_pkg::RST_ZERO;
      enh_ctrl_q <= acrb_pkg::RST_ZERO;
      patt1_lo_q <= acrb_pkg::RST_ZERO;
      patt1_hi_q <= acrb_pkg::RST_ZERO;
      patt2_lo_q <= acrb_pkg::RST_ZERO;
      patt2_hi_q <= acrb_pkg::RST_ZERO;
      ser_ctrl_q <= acrb_pkg::RST_SER_CTRL;
      override_q <= acrb_pkg::RST_ZERO;
      io_ctrl2_q <= acrb_pkg::RST_ZERO;
      io_ctrl3_q <= acrb_pkg::RST_ZERO;
      sync_q     <= acrb_pkg::RST_ZERO;
    end else begin
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_CHAN_LO)) begin
        chan_lo_q <= {4'h0, reg_wdata[3:0]};
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_CHAN_HI)) begin
        chan_hi_q <= reg_wdata & acrb_pkg::MASK_CHAN_HI;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_PWR_MODE)) begin
        pwr_mode_q <= reg_wdata & acrb_pkg::MASK_PWR_MODE;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_ENH_CTRL)) begin
        enh_ctrl_q <= reg_wdata & acrb_pkg::MASK_ENH_CTRL;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_PATT1_LO)) begin
        patt1_lo_q <= reg_wdata;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_PATT1_HI)) begin
        patt1_hi_q <= reg_wdata;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_PATT2_LO)) begin
        patt2_lo_q <= reg_wdata;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_PATT2_HI)) begin
        patt2_hi_q <= reg_wdata;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_SER_CTRL)) begin
        ser_ctrl_q <= reg_wdata;
      end
      // Shadow only; the live copy waits for the transfer bit
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_OVERRIDE)) begin
        override_q <= reg_wdata & acrb_pkg::MASK_OVERRIDE;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_IO_CTRL2)) begin
        io_ctrl2_q <= reg_wdata & acrb_pkg::MASK_IO_CTRL2;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_IO_CTRL3)) begin
        io_ctrl3_q <= reg_wdata & acrb_pkg::MASK_IO_CTRL3;
      end
      if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_SYNC)) begin
        sync_q <= reg_wdata & acrb_pkg::MASK_SYNC;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Override commit
  // -----------------------------------------------------------------------
  // A transfer write in the same cycle as an override write commits the old
  // shadow; the host must write the shadow first
  // The shadow lets a host stage a new rate without disturbing the live path
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      override_act_q <= acrb_pkg::RST_ZERO;
    end else if (hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_TRANSFER) &&
                 reg_wdata[acrb_pkg::XFER_BIT]) begin
      override_act_q <= override_q;
    end
  end

  // -----------------------------------------------------------------------
  // Per-channel status, local to selected channels
  // -----------------------------------------------------------------------
  // One strobe for all channels; each instance filters on its own select bit
  assign stat_wr = hit_wr(reg_wr, reg_addr, acrb_pkg::ADDR_CHAN_STAT);

  genvar gi;
  generate
    for (gi = 0; gi < acrb_pkg::NUM_DATA_CH + acrb_pkg::NUM_CLK_CH; gi++) begin : g_ch
      acrb_chan_ctrl u_ch (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (stat_wr),
        .wr_bits (reg_wdata[1:0]),
        .sel     (sel_vec[gi]),
        .bits_q  (stat_q[gi])
      );
    end
  endgenerate

  // Readback ORs the bits of all selected channels
  // so a mixed selection still shows any channel that is held
  always_comb begin
    stat_rd_any = 1'b0;
    stat_rd     = 8'h00;
    for (int i = 0; i < acrb_pkg::NUM_DATA_CH + acrb_pkg::NUM_CLK_CH; i++) begin
      if (sel_vec[i]) begin
        stat_rd[1:0] = stat_rd[1:0] | stat_q[i];
        stat_rd_any  = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Power mode resolution
  // -----------------------------------------------------------------------
  // The pin overrides the internal field; bit 5 chooses which mode it enters
  // The pin is a level taken as synchronous; a noisy pin needs filtering outside
  always_comb begin
    eff_mode = acrb_pkg::acrb_pmode_t'(pwr_mode_q[1:0]);
    if (external_power_down_pin) begin
      eff_mode = pwr_mode_q[acrb_pkg::PD_PIN_BIT] ? acrb_pkg::PM_STANDBY
                                                   : acrb_pkg::PM_POWERDOWN;
    end
  end

  // Global mode then per-channel power-down and output reset, registered
  // Registered so every channel switches on the same edge; costs one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Hold every path in reset and gated until the first edge sets the mode
      dp_clk_en   <= 8'h00;
      dp_reset    <= 8'hFF;
      dp_out_en   <= 8'h00;
      oclk_out_en <= 2'h0;
      oclk_reset  <= 2'h3;
    end else begin
      for (int i = 0; i < acrb_pkg::NUM_DATA_CH; i++) begin
        unique case (eff_mode)
          acrb_pkg::PM_NORMAL: begin
            dp_clk_en[i] <= !stat_q[i][acrb_pkg::STAT_PD_BIT];
            dp_reset[i]  <= stat_q[i][acrb_pkg::STAT_ORST_BIT];
            dp_out_en[i] <= !stat_q[i][acrb_pkg::STAT_PD_BIT] &&
                            !stat_q[i][acrb_pkg::STAT_ORST_BIT];
          end
          acrb_pkg::PM_POWERDOWN: begin
            dp_clk_en[i] <= 1'b0;
            dp_reset[i]  <= 1'b1;
            dp_out_en[i] <= 1'b0;
          end
          acrb_pkg::PM_STANDBY: begin
            dp_clk_en[i] <= 1'b0;
            dp_reset[i]  <= stat_q[i][acrb_pkg::STAT_ORST_BIT];
            dp_out_en[i] <= 1'b0;
          end
          acrb_pkg::PM_DIGRESET: begin
            dp_clk_en[i] <= 1'b1;
            dp_reset[i]  <= 1'b1;
            dp_out_en[i] <= 1'b0;
          end
        endcase
      end
      // Clock channels take only the output subset of the features
      // Only enable and reset reach them; clock gating stays with the data path
      for (int j = 0; j < acrb_pkg::NUM_CLK_CH; j++) begin
        oclk_out_en[j] <= (eff_mode == acrb_pkg::PM_NORMAL) &&
                          !stat_q[acrb_pkg::NUM_DATA_CH + j][acrb_pkg::STAT_PD_BIT];
        oclk_reset[j]  <= (eff_mode == acrb_pkg::PM_DIGRESET) ||
                          stat_q[acrb_pkg::NUM_DATA_CH + j][acrb_pkg::STAT_ORST_BIT];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Feature outputs, straight from flops
  // -----------------------------------------------------------------------
  // Wires only, so each feature follows its register with no extra delay
  assign chop_en                  = enh_ctrl_q[acrb_pkg::CHOP_BIT];
  assign user_pattern_one         = {patt1_hi_q, patt1_lo_q};
  assign user_pattern_two         = {patt2_hi_q, patt2_lo_q};
  assign serial_ctrl              = ser_ctrl_q;
  assign override_active          = override_act_q;
  assign sdio_pulldown_dis        = io_ctrl2_q[0];
  assign common_mode_generator_pd = io_ctrl3_q[3];
  assign sync_ctrl                = sync_q[1:0];

  // -----------------------------------------------------------------------
  // Readback
  // -----------------------------------------------------------------------
  // Unmapped addresses read zero with reg_hit low
  // The transfer register is a strobe and always reads back zero
  always_comb begin
    reg_hit   = 1'b1;
    reg_rdata = 8'h00;
    unique case (reg_addr)
      acrb_pkg::ADDR_CHAN_LO:   reg_rdata = chan_lo_q;
      acrb_pkg::ADDR_CHAN_HI:   reg_rdata = chan_hi_q;
      acrb_pkg::ADDR_PWR_MODE:  reg_rdata = pwr_mode_q;
      acrb_pkg::ADDR_ENH_CTRL:  reg_rdata = enh_ctrl_q;
      acrb_pkg::ADDR_PATT1_LO:  reg_rdata = patt1_lo_q;
      acrb_pkg::ADDR_PATT1_HI:  reg_rdata = patt1_hi_q;
      acrb_pkg::ADDR_PATT2_LO:  reg_rdata = patt2_lo_q;
      acrb_pkg::ADDR_PATT2_HI:  reg_rdata = patt2_hi_q;
      acrb_pkg::ADDR_SER_CTRL:  reg_rdata = ser_ctrl_q;
      acrb_pkg::ADDR_CHAN_STAT: reg_rdata = stat_rd_any ? stat_rd : 8'h00;
      acrb_pkg::ADDR_TRANSFER:  reg_rdata = 8'h00;
      acrb_pkg::ADDR_OVERRIDE:  reg_rdata = override_q;
      acrb_pkg::ADDR_IO_CTRL2:  reg_rdata = io_ctrl2_q;
      acrb_pkg::ADDR_IO_CTRL3:  reg_rdata = io_ctrl3_q;
      acrb_pkg::ADDR_SYNC:      reg_rdata = sync_q;
      default:                  reg_hit   = reg_rd && 1'b0;
    endcase
  end

endmodule

// [bench/acrb_regs_sva.sv]
`timescale 1ns/1ps
// ----
// Checker on the register bank ports
// ----
module acrb_regs_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register port
  input wire logic        reg_wr,
  input wire logic [8:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_hit,
  // Controls
  input wire logic        external_power_down_pin,
  input wire logic [7:0]  dp_clk_en,
  input wire logic [7:0]  dp_reset,
  input wire logic [7:0]  dp_out_en,
  input wire logic        chop_en,
  input wire logic [15:0] user_pattern_one,
  input wire logic [7:0]  serial_ctrl,
  input wire logic [7:0]  override_active
);
  logic commit_req;
  logic mode_wr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Request decodes, kept apart so sequences stay readable
  assign commit_req = reg_wr && reg_addr == acrb_pkg::ADDR_TRANSFER && reg_wdata[0];
  assign mode_wr    = reg_wr && reg_addr == acrb_pkg::ADDR_PWR_MODE;

  // Commit request on the transfer register
  sequence s_commit;
    commit_req;
  endsequence
  // Digital reset written with the pin idle, then left alone one cycle
  sequence s_dig_reset;
    mode_wr && reg_wdata[1:0] == 2'h3 && !external_power_down_pin
    ##1 !mode_wr && !external_power_down_pin;
  endsequence

  a_override_hold: assert property (!commit_req |=> $stable(override_active))
    else $error("override changed without a commit");
  a_commit_seen: cover property (s_commit);
  a_dig_reset: assert property (s_dig_reset |=>
    dp_reset == 8'hFF && dp_clk_en == 8'hFF && dp_out_en == 8'h00)
    else $error("digital reset outputs wrong");
  a_pin_gates: assert property (external_power_down_pin [*3] |->
    dp_clk_en == 8'h00 && dp_out_en == 8'h00)
    else $error("pin did not gate clocks and outputs");
  a_out_needs_clk: assert property ((dp_out_en & ~dp_clk_en) == 8'h00)
    else $error("output enabled with clock gated");
  a_chop_view: assert property (reg_wr && reg_addr == acrb_pkg::ADDR_ENH_CTRL |=>
    chop_en == $past(reg_wdata[acrb_pkg::CHOP_BIT]))
    else $error("chop output differs from register");
  a_serial_view: assert property (reg_addr == acrb_pkg::ADDR_SER_CTRL |->
    reg_rdata == serial_ctrl)
    else $error("serial control output differs");
  a_patt_write: assert property (reg_wr && reg_addr == acrb_pkg::ADDR_PATT1_LO |=>
    user_pattern_one[7:0] == $past(reg_wdata))
    else $error("pattern low byte not updated");
  a_patt_high: assert property (reg_addr == acrb_pkg::ADDR_PATT1_HI |->
    user_pattern_one[15:8] == reg_rdata)
    else $error("pattern high byte misplaced");
  a_unmapped_zero: assert property (!reg_hit |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind acrb_regs acrb_regs_sva u_acrb_regs_sva (.sys_clk, .rst, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_hit, .external_power_down_pin, .dp_clk_en, .dp_reset,
  .dp_out_en, .chop_en, .user_pattern_one, .serial_ctrl, .override_active);

// [bench/acrb_host.sv]
`timescale 1ns/1ps
// ----
// Host controller on the register port
// ----
module acrb_host (
  // Clock
  input wire logic        sys_clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [8:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_hit
);
  // Idle port; released lines show the inverse so stale values never match
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
  end

  // One write, taken at the edge after it is set up
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // One read, data taken at the edge that ends it
  task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic h);
    @(posedge sys_clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    d = reg_rdata;
    h = reg_hit;
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  // Commit the override shadow
  task automatic commit();
    wr(acrb_pkg::ADDR_TRANSFER, 8'h01);
  endtask

  // Re-initialise once the clock is stable
  task automatic reinit();
    wr(acrb_pkg::ADDR_PWR_MODE, 8'h03);
    wr(acrb_pkg::ADDR_PWR_MODE, 8'h00);
  endtask
endmodule

// [bench/adc_control_register_bank_test.sv]
`timescale 1ns/1ps
module adc_control_register_bank_test;
  logic        sys_clk, rst, reg_wr, reg_rd, reg_hit, pd_pin, chop_en, sdio_dis, cm_pd, hv;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, dp_clk_en, dp_reset, dp_out_en, ser_ctrl, ovr, rv;
  logic [1:0]  oclk_out_en, oclk_reset, sync_ctrl;
  logic [15:0] patt_one, patt_two;
  int          mismatches;
  int          compares;
  // Expected data path controls per internal mode
  logic [7:0]  ek [4] = '{8'hFF, 8'h00, 8'h00, 8'hFF};
  logic [7:0]  er [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
  logic [7:0]  eo [4] = '{8'hFF, 8'h00, 8'h00, 8'h00};
  logic [8:0]  ra [12] = '{9'h004, 9'h005, 9'h008, 9'h00C, 9'h019, 9'h01A, 9'h01B, 9'h01C,
                           9'h021, 9'h022, 9'h101, 9'h109};
  logic [7:0]  rx [12] = '{8'h0F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h42, 8'h00, 8'h00, 8'h00};

  acrb_regs u_acrb_regs (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .external_power_down_pin(pd_pin), .dp_clk_en(dp_clk_en), .dp_reset(dp_reset),
    .dp_out_en(dp_out_en), .oclk_out_en(oclk_out_en), .oclk_reset(oclk_reset),
    .chop_en(chop_en), .user_pattern_one(patt_one), .user_pattern_two(patt_two),
    .serial_ctrl(ser_ctrl), .override_active(ovr), .sdio_pulldown_dis(sdio_dis),
    .common_mode_generator_pd(cm_pd), .sync_ctrl(sync_ctrl));
  acrb_host u_acrb_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
    u_acrb_host.rd(a, rv, hv);
    chk($sformatf("reg %h", a), {8'h00, rv}, {8'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pwr(input int m);
    chk("clk_en", {8'h00, dp_clk_en}, {8'h00, ek[m]});
    chk("dp_reset", {8'h00, dp_reset}, {8'h00, er[m]});
    chk("out_en", {8'h00, dp_out_en}, {8'h00, eo[m]});
    chk("oclk_en", {14'h0, oclk_out_en}, (m == 0) ? 16'h0003 : 16'h0000);
    chk("oclk_rst", {14'h0, oclk_reset}, (m == 3) ? 16'h0003 : 16'h0000);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Clock at 250 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst = 1'b1;
    pd_pin = 1'b0;
    mismatches = 0;
    compares = 0;
    tick(5);
    rst = 1'b0;
    tick(2);
    for (int i = 0; i < 12; i++) rchk(ra[i], rx[i]);
    chk("ser_ctrl", {8'h00, ser_ctrl}, 16'h0042);
    pwr(0);
    chk("oclk_en", {14'h0, oclk_out_en}, 16'h0003);
    $display("reset test done");
    // Globals with only channel 0 selected
    u_acrb_host.wr(9'h004, 8'h01);
    u_acrb_host.wr(9'h005, 8'h00);
    u_acrb_host.wr(9'h019, 8'hA5);
    u_acrb_host.wr(9'h01A, 8'h3C);
    u_acrb_host.wr(9'h01B, 8'h0F);
    u_acrb_host.wr(9'h01C, 8'hF0);
    u_acrb_host.wr(9'h101, 8'hFF);
    u_acrb_host.wr(9'h102, 8'hFF);
    u_acrb_host.wr(9'h109, 8'hFF);
    u_acrb_host.wr(9'h00C, 8'hFF);
    tick(1);
    chk("patt_one", patt_one, 16'h3CA5);
    chk("patt_two", patt_two, 16'hF00F);
    chk("misc", {11'h0, sdio_dis, cm_pd, chop_en, sync_ctrl}, 16'h001F);
    rchk(9'h102, 8'h08);
    u_acrb_host.wr(9'h00C, 8'h00);
    rchk(9'h00C, 8'h00);
    chk("chop", {15'h0, chop_en}, 16'h0000);
    $display("global test done");
    // Local status on selected channels only
    u_acrb_host.wr(9'h022, 8'h01);
    tick(1);
    chk("clk_en", {8'h00, dp_clk_en}, 16'h00FE);
    chk("out_en", {8'h00, dp_out_en}, 16'h00FE);
    rchk(9'h022, 8'h01);
    u_acrb_host.wr(9'h004, 8'h02);
    rchk(9'h022, 8'h00);
    u_acrb_host.wr(9'h004, 8'h00);
    u_acrb_host.wr(9'h005, 8'h10);
    u_acrb_host.wr(9'h022, 8'h01);
    tick(1);
    chk("oclk_en", {14'h0, oclk_out_en}, 16'h0002);
    u_acrb_host.wr(9'h004, 8'h0F);
    u_acrb_host.wr(9'h005, 8'hFF);
    u_acrb_host.wr(9'h022, 8'h02);
    tick(1);
    chk("dp_reset", {8'h00, dp_reset}, 16'h00FF);
    chk("oclk_rst", {14'h0, oclk_reset}, 16'h0003);
    chk("out_en", {8'h00, dp_out_en}, 16'h0000);
    u_acrb_host.wr(9'h022, 8'h00);
    rchk(9'h005, 8'h3F);
    chk("hit", {15'h0, hv}, 16'h0001);
    rchk(9'h1FF, 8'h00);
    chk("hit", {15'h0, hv}, 16'h0000);
    pwr(0);
    $display("local test done");
    // Override waits for the commit
    u_acrb_host.wr(9'h100, 8'hC5);
    u_acrb_host.wr(9'h0FF, 8'h00);
    tick(2);
    chk("override", {8'h00, ovr}, 16'h0000);
    u_acrb_host.commit();
    tick(1);
    chk("override", {8'h00, ovr}, 16'h0045);
    rchk(9'h0FF, 8'h00);
    $display("override test done");
    // Internal power modes, registers survive digital reset
    u_acrb_host.wr(9'h019, 8'h5A);
    for (int m = 1; m < 4; m++) begin
      u_acrb_host.wr(9'h008, m[7:0]);
      tick(1);
      pwr(m);
    end
    rchk(9'h019, 8'h5A);
    rchk(9'h008, 8'h03);
    u_acrb_host.reinit();
    tick(1);
    pwr(0);
    $display("mode test done");
    // Pin picks standby or power-down
    u_acrb_host.wr(9'h008, 8'h20);
    pd_pin = 1'b1;
    tick(3);
    pwr(2);
    pd_pin = 1'b0;
    u_acrb_host.wr(9'h008, 8'h00);
    pd_pin = 1'b1;
    tick(3);
    pwr(1);
    pd_pin = 1'b0;
    tick(3);
    pwr(0);
    $display("pin test done");
    // Only power-on reset clears the registers
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    rchk(9'h019, 8'h00);
    rchk(9'h021, 8'h42);
    $display("reset again test done");
    summarize();
  end
endmodule
